// [include/ocs_regs.svh]
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH
// Register offsets
`define OCS_ADDR_OCP 6'h0E
`define OCS_ADDR_GAIN 6'h0F
`define OCS_ADDR_CAL 6'h10
// Reset values
`define OCS_RST_OCP 8'h00
`define OCS_RST_GAIN 8'h2A
`define OCS_RST_CAL 8'h7F
// Overcurrent protection control fields
`define OCS_BIT_TEMP_REP 6
`define OCS_BIT_CBC 5
`define OCS_BIT_DIS_C 4
`define OCS_BIT_DIS_B 3
`define OCS_BIT_DIS_A 2
// Gain control fields
`define OCS_BIT_LOW_SIDE_MEASURE_REFERENCE 7
`define OCS_BIT_AMP_SEL 6
// Calibration control fields
`define OCS_BIT_CAL_AUTO 7
`define OCS_BIT_VREF_HALF 6
// Lock patterns
`define OCS_LOCK_ON 3'h6
`define OCS_LOCK_OFF 3'h3
`endif

// [include/ocs_pkg.sv]
package ocs_pkg;
    // Overcurrent response encodings
    typedef enum logic [1:0] {
        OCS_LATCH = 2'b00,
        OCS_RETRY = 2'b01,
        OCS_REPORT = 2'b10,
        OCS_IGNORE = 2'b11
    } ocs_mode_e;
    // Register write request
    typedef struct packed {
        logic en;
        logic [5:0] addr;
        logic [7:0] data;
    } ocs_wr_s;
    // Decoded per-phase settings
    typedef struct packed {
        logic [1:0] gain;
        logic [1:0] trip;
        logic trip_off;
    } ocs_phase_s;
endpackage : ocs_pkg

// [design/ocs_phase.sv]
`timescale 1ns/100ps
// One phase of sense amplifier and trip settings, registered
module ocs_phase
    import ocs_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [1:0] gain_i,
    input wire logic [1:0] trip_i,
    input wire logic trip_off_i,
    output ocs_phase_s phase_o
);
    ocs_phase_s phase_d;
    ocs_phase_s phase_q;

    // Pack the settings of this phase
    always_comb begin
        phase_d.gain = gain_i;
        phase_d.trip = trip_i;
        phase_d.trip_off = trip_off_i;
    end

    // Register so outputs come from flops
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_q <= '{gain: 2'h2, trip: 2'h3, trip_off: 1'b0};
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_o = phase_q;
endmodule : ocs_phase

// [design/ocs_regbank.sv]
`timescale 1ns/100ps
`include "ocs_regs.svh"
// What this block does
// - Warning routing drives temperature warning to the fault pin only, not the fault report
// - Cycle-by-cycle retry clears fault on PWM edge
// - Per-phase bits disable drain-source trips
// - Mode 00 latches fault until clear
// - Mode 01 retries and self-clears
// - Mode 10 reports only, gates untouched
// - Mode 11 neither reports nor acts
// - Low-side reference selects source or ground
// - Input select 0 uses sense-positive pin
// - Input select 1 uses drain, forces reference
// - Per-phase gain 5/10/20/40, default 20
// - Calibration bit selects auto or manual
// - Reference divide bit selects half reference
// - Lock pattern blocks writes; unlock restores
module ocs_regbank
    import ocs_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input ocs_wr_s wr_i,
    input wire logic [5:0] rd_addr_i,
    input wire logic lock_wr_i,
    input wire logic [2:0] lock_data_i,
    input wire logic fault_clear_i,
    input wire logic temp_warning_i,
    input wire logic [2:0] drain_source_overcurrent_i,
    input wire logic [2:0] shunt_overcurrent_i,
    input wire logic pwm_edge_i,
    input wire logic retry_done_i,
    output logic [7:0] rd_data_o,
    output logic locked_o,
    output logic fault_output_low_active_o,
    output logic fault_report_o,
    output logic gate_shutdown_o,
    output logic [1:0] overcurrent_response_select_o,
    output logic low_side_measure_reference_o,
    output logic amplifier_input_select_o,
    output logic cal_auto_o,
    output logic vref_half_o,
    output ocs_phase_s [2:0] phase_cfg_o
);
    logic [7:0] ocp_q, ocp_d;      // Overcurrent protection control
    logic [7:0] gain_q, gain_d;    // Sense amplifier gain control
    logic [7:0] cal_q, cal_d;      // Calibration and threshold control
    logic lock_q, lock_d;          // Write lock state
    logic fault_q, fault_d;        // Overcurrent fault state
    logic [7:0] rd_q, rd_d;        // Read-back data
    logic fault_output_low_active_q, fault_output_low_active_d;      // Fault pin, low active
    logic rep_q, rep_d;            // Fault reported flag
    logic shut_q, shut_d;          // Gate shutdown request
    logic [2:0] vds_hit;           // Qualified drain-source trips
    logic oc_event;                // Any qualified overcurrent
    ocs_mode_e mode;               // Current response mode

    // Register writes, lock handling
    always_comb begin
        ocp_d = ocp_q;
        gain_d = gain_q;
        cal_d = cal_q;
        lock_d = lock_q;
        // Lock writes pass even while locked, or it could never unlock
        // lock pattern decode
        if (lock_wr_i) begin
            if (!lock_q && lock_data_i == `OCS_LOCK_ON) begin
                lock_d = 1'b1;
            end else if (lock_q && lock_data_i == `OCS_LOCK_OFF) begin
                lock_d = 1'b0;
            end
        end
        if (wr_i.en && !lock_q) begin
            case (wr_i.addr)
                `OCS_ADDR_OCP: begin
                    ocp_d = wr_i.data;
                end
                `OCS_ADDR_GAIN: begin
                    gain_d = wr_i.data;
                    if (wr_i.data[`OCS_BIT_AMP_SEL]) begin
                        gain_d[`OCS_BIT_LOW_SIDE_MEASURE_REFERENCE] = 1'b1;
                    end
                end
                `OCS_ADDR_CAL: begin
                    cal_d = wr_i.data;
                end
                default: begin
                    // Unmapped addresses are dropped silently
                end
            endcase
        end
    end

    // Register bank flops, documented defaults out of reset
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ocp_q <= `OCS_RST_OCP;
            gain_q <= `OCS_RST_GAIN;
            cal_q <= `OCS_RST_CAL;
            lock_q <= 1'b0;
        end else begin
            ocp_q <= ocp_d;
            gain_q <= gain_d;
            cal_q <= cal_d;
            lock_q <= lock_d;
        end
    end

    // Fault handling per response mode
    always_comb begin
        mode = ocs_mode_e'(ocp_q[1:0]);
        vds_hit = drain_source_overcurrent_i & ~ocp_q[`OCS_BIT_DIS_C:`OCS_BIT_DIS_A];
        // Disables gate drain-source trips only; shunt trips still count
        oc_event = (|vds_hit) | (|shunt_overcurrent_i);
        // Event wins over a clear that lands in the same cycle
        fault_d = fault_q;
        case (mode)
            OCS_LATCH: begin
                if (oc_event) begin
                    fault_d = 1'b1;
                end else if (fault_clear_i) begin
                    fault_d = 1'b0;
                end
            end
            OCS_RETRY: begin
                if (oc_event) begin
                    fault_d = 1'b1;
                end else if (ocp_q[`OCS_BIT_CBC] && pwm_edge_i) begin
                    fault_d = 1'b0;
                end else if (retry_done_i || fault_clear_i) begin
                    fault_d = 1'b0;
                end
            end
            OCS_REPORT: begin
                if (oc_event) begin
                    fault_d = 1'b1;
                end else if (fault_clear_i) begin
                    fault_d = 1'b0;
                end
            end
            default: begin
                fault_d = 1'b0;
            end
        endcase
        // Report follows the fault state in every mode
        rep_d = fault_d;
        shut_d = fault_d && (mode == OCS_LATCH || mode == OCS_RETRY);
        fault_output_low_active_d = !(fault_d || (ocp_q[`OCS_BIT_TEMP_REP] && temp_warning_i));
    end

    // Fault flops; pin idles high so reset shows no fault
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_q <= 1'b0;
            rep_q <= 1'b0;
            shut_q <= 1'b0;
            fault_output_low_active_q <= 1'b1;
        end else begin
            fault_q <= fault_d;
            rep_q <= rep_d;
            shut_q <= shut_d;
            fault_output_low_active_q <= fault_output_low_active_d;
        end
    end

    // Read-back mux
    always_comb begin
        // Unmapped addresses read back as zero
        case (rd_addr_i)
            `OCS_ADDR_OCP: rd_d = ocp_q;
            `OCS_ADDR_GAIN: rd_d = gain_q;
            `OCS_ADDR_CAL: rd_d = cal_q;
            default: rd_d = 8'h00;
        endcase
    end

    // Read data flop; answer stands one cycle after the address
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_q <= 8'h00;
        end else begin
            rd_q <= rd_d;
        end
    end

    // Per-phase settings, one flop stage behind the bank
    // per-phase amplifier gains
    for (genvar p = 0; p < 3; p++) begin : g_phase
        ocs_phase u_phase (
            .clock_i(clock_i),
            .resetn_i(resetn_i),
            .gain_i(gain_q[2*p+1:2*p]),
            .trip_i(cal_q[2*p+1:2*p]),
            .trip_off_i(ocp_q[`OCS_BIT_DIS_A+p]),
            .phase_o(phase_cfg_o[p])
        );
    end

    // Outputs come straight from flops, no logic after them
    assign rd_data_o = rd_q;
    assign locked_o = lock_q;
    assign fault_output_low_active_o = fault_output_low_active_q;
    assign fault_report_o = rep_q;
    assign gate_shutdown_o = shut_q;
    assign overcurrent_response_select_o = ocp_q[1:0];
    assign low_side_measure_reference_o = gain_q[`OCS_BIT_LOW_SIDE_MEASURE_REFERENCE];
    assign amplifier_input_select_o = gain_q[`OCS_BIT_AMP_SEL];
    assign cal_auto_o = cal_q[`OCS_BIT_CAL_AUTO];
    assign vref_half_o = cal_q[`OCS_BIT_VREF_HALF];
endmodule : ocs_regbank

// [verification/ocs_regbank_asserts.sv]
`timescale 1ns/100ps
`include "ocs_regs.svh"
// Ties register outputs to accepted writes
module ocs_regbank_asserts
    import ocs_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input ocs_wr_s wr_i,
    input wire logic locked_o,
    input wire logic [2:0] shunt_overcurrent_i,
    input wire logic fault_report_o,
    input wire logic gate_shutdown_o,
    input wire logic [1:0] overcurrent_response_select_o,
    input wire logic low_side_measure_reference_o,
    input wire logic amplifier_input_select_o,
    input wire logic cal_auto_o,
    input wire logic vref_half_o,
    input ocs_phase_s [2:0] phase_cfg_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Write taken at one address
    sequence s_wr(a);
        wr_i.en && wr_i.addr == a && !locked_o;
    endsequence
    AST_MODE: assert property (s_wr(`OCS_ADDR_OCP) |=>
        overcurrent_response_select_o == $past(wr_i.data[1:0])) else $error("mode lost");
    AST_LOCK: assert property (locked_o && wr_i.en |=>
        $stable({cal_auto_o, vref_half_o, low_side_measure_reference_o,
        amplifier_input_select_o, overcurrent_response_select_o}))
        else $error("write taken while locked");
    AST_FET: assert property (s_wr(`OCS_ADDR_GAIN) ##0 wr_i.data[6] |=>
        low_side_measure_reference_o && amplifier_input_select_o) else $error("no force");
    AST_REF: assert property (s_wr(`OCS_ADDR_GAIN) ##0 !wr_i.data[6] |=>
        low_side_measure_reference_o == $past(wr_i.data[7])) else $error("reference bad");
    AST_CAL: assert property (s_wr(`OCS_ADDR_CAL) |=>
        {cal_auto_o, vref_half_o} == $past(wr_i.data[7:6])) else $error("cal bad");
    AST_GAIN: assert property (s_wr(`OCS_ADDR_GAIN) |=> ##1
        phase_cfg_o[0].gain == $past(wr_i.data[1:0], 2)) else $error("gain bad");
    AST_IGNORE: assert property ((overcurrent_response_select_o == 2'h3) [*2]
        |-> !fault_report_o) else $error("ignored fault shown");
    AST_REPORT: assert property (overcurrent_response_select_o == 2'h2 &&
        shunt_overcurrent_i != 3'h0 |=> fault_report_o && !gate_shutdown_o)
        else $error("report mode bad");
endmodule : ocs_regbank_asserts
bind ocs_regbank ocs_regbank_asserts u_ocs_regbank_asserts (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .wr_i(wr_i),
    .locked_o(locked_o),
    .shunt_overcurrent_i(shunt_overcurrent_i),
    .fault_report_o(fault_report_o),
    .gate_shutdown_o(gate_shutdown_o),
    .overcurrent_response_select_o(overcurrent_response_select_o),
    .low_side_measure_reference_o(low_side_measure_reference_o),
    .amplifier_input_select_o(amplifier_input_select_o),
    .cal_auto_o(cal_auto_o),
    .vref_half_o(vref_half_o),
    .phase_cfg_o(phase_cfg_o)
);

// [verification/ocs_host.sv]
`timescale 1ns/100ps
`include "ocs_regs.svh"
// Host model: register writes, reads and lock requests
module ocs_host
    import ocs_pkg::*;
(
    input wire logic clock_i,
    output ocs_wr_s wr_o,
    output logic [5:0] rd_addr_o,
    output logic rd_v_o,
    output logic lock_wr_o,
    output logic [2:0] lock_data_o
);
    initial begin
        wr_o = '0;
        {rd_addr_o, rd_v_o, lock_wr_o, lock_data_o} = '0;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_o <= '{1'b1, a, (a == `OCS_ADDR_OCP) ? d & 8'h7F : d};
        @(posedge clock_i);
        wr_o <= '{1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge clock_i);
        {rd_addr_o, rd_v_o} <= {a, 1'b1};
        @(posedge clock_i);
        {rd_addr_o, rd_v_o} <= {~a, 1'b0};
    endtask : rd
    task automatic lock(input logic [2:0] p);
        @(posedge clock_i);
        {lock_wr_o, lock_data_o} <= {1'b1, p};
        @(posedge clock_i);
        {lock_wr_o, lock_data_o} <= {1'b0, ~p};
    endtask : lock
endmodule : ocs_host

// [verification/ocs_regbank_test.sv]
`timescale 1ns/100ps
`include "ocs_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ocs_regbank_test;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    ocs_pkg::ocs_wr_s wr;
    ocs_pkg::ocs_phase_s [2:0] ph;
    logic [5:0] ra;
    logic rv, rv_q, lw, lk, fc, tw, pe, rdn, rpt, sd, lsr, ams, flt_n, ca, vh;
    logic [18:0] ecf;
    logic [2:0] ld, dso, sho;
    logic [1:0] md;
    logic [7:0] rdd, g, c, ex;
    logic [31:0] rng = 32'h0000_6B42;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    always #10 clock_i = ~clock_i;
    ocs_host u_ocs_host (.clock_i(clock_i), .wr_o(wr), .rd_addr_o(ra), .rd_v_o(rv),
        .lock_wr_o(lw), .lock_data_o(ld));
    ocs_regbank u_ocs_regbank (.clock_i(clock_i), .resetn_i(resetn_i), .wr_i(wr),
        .rd_addr_i(ra), .lock_wr_i(lw), .lock_data_i(ld), .fault_clear_i(fc),
        .temp_warning_i(tw), .drain_source_overcurrent_i(dso), .shunt_overcurrent_i(sho),
        .pwm_edge_i(pe), .retry_done_i(rdn), .rd_data_o(rdd), .locked_o(lk),
        .fault_output_low_active_o(flt_n), .fault_report_o(rpt), .gate_shutdown_o(sd),
        .overcurrent_response_select_o(md), .low_side_measure_reference_o(lsr),
        .amplifier_input_select_o(ams), .cal_auto_o(ca), .vref_half_o(vh), .phase_cfg_o(ph));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic at(input int n);
        repeat (n) @(posedge clock_i);
    endtask : at
    // Note the expected byte, then read
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_ocs_host.rd(a);
    endtask : rd
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    // Read data against the oldest note, plus cycle ceiling
    always @(posedge clock_i) begin
        rv_q <= rv;
        cyc++;
        if (rv_q) begin
            ex = exp_q.pop_front();
            `CHK(rdd, ex)
        end
        if (cyc == 3000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        {fc, tw, pe, rdn, dso, sho} = '0;
        at(4);
        resetn_i <= 1'b1;
        rd(`OCS_ADDR_OCP, `OCS_RST_OCP);
        rd(`OCS_ADDR_GAIN, `OCS_RST_GAIN);
        rd(`OCS_ADDR_CAL, `OCS_RST_CAL);
        rd(6'h11, 8'h00);
        $display("end reset");
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            g = rng[6] ? rng[7:0] | 8'hC0 : rng[7:0];
            c = rng[15:8];
            u_ocs_host.wr(`OCS_ADDR_GAIN, rng[7:0]);
            u_ocs_host.wr(`OCS_ADDR_CAL, c);
            rd(`OCS_ADDR_GAIN, g);
            rd(`OCS_ADDR_CAL, c);
            ecf = {g[7:6], c[7:6], g[5:4], c[5:4], 1'b0, g[3:2], c[3:2], 1'b0,
                g[1:0], c[1:0], 1'b0};
            #1;
            `CHK({lsr, ams, ca, vh, ph}, ecf)
        end
        u_ocs_host.lock(`OCS_LOCK_ON);
        u_ocs_host.wr(`OCS_ADDR_GAIN, 8'h15);
        rd(`OCS_ADDR_GAIN, g);
        #1;
        `CHK(lk, 1'b1)
        u_ocs_host.lock(`OCS_LOCK_OFF);
        u_ocs_host.wr(`OCS_ADDR_GAIN, 8'h15);
        rd(`OCS_ADDR_GAIN, 8'h15);
        $display("end lock");
        for (int m = 0; m < 4; m++) begin
            u_ocs_host.wr(`OCS_ADDR_OCP, 8'(m));
            sho <= 3'h2;
            at(1);
            #1;
            `CHK({md, rpt, sd}, {2'(m), m != 3, m < 2})
            at(1);
            {sho, fc, rdn} <= 5'h03;
            at(1);
            {fc, rdn} <= 2'h0;
            at(1);
            #1;
            `CHK(rpt, 1'b0)
        end
        u_ocs_host.wr(`OCS_ADDR_OCP, 8'h21);
        sho <= 3'h4;
        at(1);
        #1;
        `CHK({rpt, sd}, 2'h3)
        at(1);
        {sho, pe} <= 4'h1;
        at(1);
        pe <= 1'b0;
        #1;
        `CHK(rpt, 1'b0)
        u_ocs_host.wr(`OCS_ADDR_OCP, 8'h04);
        dso <= 3'h1;
        at(1);
        dso <= 3'h2;
        #1;
        `CHK(rpt, 1'b0)
        `CHK({ph[2].trip_off, ph[1].trip_off, ph[0].trip_off}, 3'h1)
        at(1);
        {dso, fc} <= 4'h1;
        #1;
        `CHK(rpt, 1'b1)
        at(1);
        fc <= 1'b0;
        u_ocs_host.wr(`OCS_ADDR_OCP, 8'h40);
        tw <= 1'b1;
        at(2);
        #1;
        `CHK(flt_n, 1'b0)
        u_ocs_host.wr(`OCS_ADDR_OCP, 8'h00);
        at(1);
        #1;
        `CHK(flt_n, 1'b1)
        $display("end faults");
        end_of_test();
    end
endmodule : ocs_regbank_test
